// file: hw/smp_defs.svh
/* smp constants: instruction codes, fields, wait times, sizes.
   assumes inclusion by bare name. */
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

// core clock rate
`define SMP_CLK_MHZ        20

// self-timed write durations in microseconds
`define SMP_FLASH_WAIT_US  5000
`define SMP_EE_WAIT_US     10000
`define SMP_ERASE_WAIT_US  10000

// instruction bytes
`define SMP_ENABLE_B1      8'hac
`define SMP_ENABLE_B2      8'h53
`define SMP_ERASE_B2_TOP   3'h4
`define SMP_WR_PAGE_B1     8'h4c
`define SMP_RD_EE_B1       8'ha0
`define SMP_WR_EE_B1       8'hc0
`define SMP_RD_FLASH_HI    4'h2
`define SMP_LD_PAGE_HI     4'h4
`define SMP_B1_LOW_ZERO    3'h0

// field positions
`define SMP_B1_HBIT        3
`define SMP_PAGE_LSB       7
`define SMP_EE_HI_BITS     4

// link framing
`define SMP_BIT_LAST       3'h7
`define SMP_BYTE_THIRD     2'h2
`define SMP_ALL_ONES       8'hff
`define SMP_STRAP_DONE     2'h3
`define SMP_RD_CAPTURE     2'h1
`define SMP_RD_START       2'h2

// command buffer
`define SMP_FIFO_DEPTH     32
`define SMP_ADDR_W         16
`define SMP_DATA_W         8

`endif

// file: hw/smp_pkg.sv
/* smp_pkg: port types.
   assumes smp_defs.svh on the include path. */
`include "smp_defs.svh"

package smp_pkg;

    // array commands
    typedef enum logic [2:0] {
        SMP_OP_LOAD_LO    = 3'h0,
        SMP_OP_LOAD_HI    = 3'h1,
        SMP_OP_WR_PAGE    = 3'h2,
        SMP_OP_EE_ERASE   = 3'h3,
        SMP_OP_EE_WRITE   = 3'h4,
        SMP_OP_CHIP_ERASE = 3'h5
    } smp_op_t;

    // programming mode, one-hot
    typedef enum logic [2:0] {
        SMP_MODE_OFF     = 3'h1,
        SMP_MODE_WAIT_EN = 3'h2,
        SMP_MODE_ENABLED = 3'h4
    } smp_mode_t;

    // busy kind
    typedef enum logic [1:0] {
        SMP_BUSY_FLASH = 2'h0,
        SMP_BUSY_EE    = 2'h1,
        SMP_BUSY_ERASE = 2'h2
    } smp_busy_t;

    localparam int SMP_CMD_W = 3 + `SMP_ADDR_W + `SMP_DATA_W;

endpackage

// file: hw/smp_fifo.sv
/* smp_fifo: fifo with registered output word.
   assumes one clock, async active-low reset, depth a power of two. */
`timescale 1ns/10ps
`include "smp_defs.svh"

module smp_fifo #(
    parameter int WIDTH = smp_pkg::SMP_CMD_W,
    parameter int DEPTH = `SMP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import smp_pkg::*;

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
        $error("smp_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
        logic                        full;
    } smp_fifo_st_t;

    smp_fifo_st_t st_r;
    smp_fifo_st_t st_nxt;

    always_comb
    begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        st_nxt = st_r;
        push = in_valid && !st_r.full;
        // output stage refills whenever it is empty or being taken
        pop = (st_r.cnt != '0) && (!st_r.ov || out_ready);
        if (st_r.ov && out_ready)
        begin
            st_nxt.ov = 1'b0;
        end
        if (pop)
        begin
            st_nxt.ov = 1'b1;
            st_nxt.od = st_r.mem[st_r.rp];
            st_nxt.rp = st_r.rp + 1'b1;
        end
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // registered full keeps in_ready off any combinational path
        st_nxt.full = (st_nxt.cnt == (AW+1)'(DEPTH));
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = !st_r.full;
    assign out_valid = st_r.ov;
    assign out_data  = st_r.od;

endmodule

// file: hw/smp_prog_port.sv
/* smp_prog_port: serial programming port; decodes instructions,
   answers reads, queues array writes.
   assumes the array answers a read one cycle after rd_req. */
`timescale 1ns/10ps
`include "smp_defs.svh"

// Operation
// R01 - programming accepted only while the device reset pin is held low
// R02 - program and erase act only after the programming-enable instruction
// R03 - data uses the alternate pins, clock the serial clock pin
// R04 - an eeprom byte write first erases that byte automatically
// R05 - chip erase sets every flash and eeprom location to all ones
// R06 - programmer holds each serial clock phase over 3 cpu clocks here
// R07 - incoming data sampled on serial clock rising edge
// R08 - outgoing data shifted on serial clock falling edge
// R09 - programmer powers up with reset and clock low, else pulses reset
// R10 - select pin low at power-on reset enters mode until power down
// R11 - programmer waits 20 ms after entry before programming-enable
// R12 - second enable byte echoes while third byte shifts in
// R13 - programmer sends all four enable bytes, resyncs by reset pulse
// R14 - page buffer loaded per byte at 7 address bits, low byte first
// R15 - write-page commits buffer to page at 9 upper address bits
// R16 - without polling programmer waits flash page time between pages
// R17 - only polling reads allowed while a write is in progress
// R18 - eeprom written one byte per instruction, programmer waits byte time
// R19 - read instruction shifts out the addressed location's content
// R20 - releasing reset high leaves programming mode
// R21 - reads inside a page being written return all ones until done
// R22 - programmer cannot poll all-ones values and waits full time
// R23 - programmer waits 5, 10, 10 and 4.5 ms minimum after writes
// R24 - enable instruction is ac, 53, then two don't-care bytes
// R25 - instructions are four bytes, each shifted msb first
module smp_prog_port #(
    parameter int FLASH_WAIT_CYC = `SMP_FLASH_WAIT_US * `SMP_CLK_MHZ,
    parameter int EE_WAIT_CYC    = `SMP_EE_WAIT_US * `SMP_CLK_MHZ,
    parameter int ERASE_WAIT_CYC = `SMP_ERASE_WAIT_US * `SMP_CLK_MHZ,
    parameter int FIFO_DEPTH     = `SMP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    // programming pins
    input  wire logic                     dev_reset_pin_n,
    input  wire logic                     serial_program_select_pin_n,
    input  wire logic                     serial_clock_pin,
    input  wire logic                     alt_serial_in_pin,
    output logic                          alt_serial_out_pin,
    output logic                          alt_serial_out_oe,
    // status
    output logic                          prog_mode,
    output logic                          prog_enabled,
    output logic                          nvm_busy,
    // read port to the arrays
    output logic                          rd_req,
    output logic                          rd_flash,
    output logic                          rd_hi,
    output logic [`SMP_ADDR_W-1:0]        rd_addr,
    input  wire logic [`SMP_DATA_W-1:0]   rd_data,
    // command stream to the arrays
    output logic                          cmd_valid,
    input  wire logic                     cmd_ready,
    output smp_pkg::smp_op_t              cmd_op,
    output logic [`SMP_ADDR_W-1:0]        cmd_addr,
    output logic [`SMP_DATA_W-1:0]        cmd_data
);
    import smp_pkg::*;

    localparam int MAXW  = (EE_WAIT_CYC > FLASH_WAIT_CYC) ? EE_WAIT_CYC : FLASH_WAIT_CYC;
    localparam int MAXW2 = (ERASE_WAIT_CYC > MAXW) ? ERASE_WAIT_CYC : MAXW;
    localparam int CNT_W = $clog2(MAXW2 + 1);

    if (FLASH_WAIT_CYC < 1 || EE_WAIT_CYC < 1 || ERASE_WAIT_CYC < 1)
    begin : g_bad
        $error("smp_prog_port: wait counts must be at least one cycle");
    end

    typedef struct packed {
        logic [1:0]             sck_s;
        logic                   sck_d;
        logic [1:0]             sdi_s;
        logic [1:0]             rstp_s;
        logic [1:0]             pen_s;
        logic [1:0]             strap_cnt;
        logic                   pen_mode;
        smp_mode_t              mode;
        logic [2:0]             bit_cnt;
        logic [1:0]             byte_cnt;
        logic [7:0]             in_sr;
        logic [7:0]             b1;
        logic [7:0]             b2;
        logic [7:0]             b3;
        logic [7:0]             out_sr;
        logic                   out_bit;
        logic                   out_oe;
        logic                   in_mode;
        logic                   rd_req;
        logic                   rd_flash;
        logic                   rd_hi;
        logic [`SMP_ADDR_W-1:0] rd_addr;
        logic [1:0]             rd_wait;
        logic                   rd_ff;
        logic                   q_valid;
        smp_op_t                q_op;
        logic [`SMP_ADDR_W-1:0] q_addr;
        logic [`SMP_DATA_W-1:0] q_data;
        logic                   busy;
        smp_busy_t              busy_kind;
        logic [CNT_W-1:0]       busy_cnt;
        logic [`SMP_ADDR_W-1:0] busy_addr;
    } smp_state_t;

    smp_state_t st_r;
    smp_state_t st_nxt;
    logic       q_ready;

    always_comb
    begin
        logic       sck_rise;
        logic       sck_fall;
        logic       in_mode;
        logic [7:0] byte_in;
        logic [7:0] b1;
        logic [`SMP_ADDR_W-1:0] addr;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        in_mode = 1'b0;
        byte_in = '0;
        b1 = '0;
        addr = '0;
        st_nxt = st_r;
        st_nxt.rd_req = 1'b0;

        // two-flop synchronisers
        st_nxt.sck_s  = {st_r.sck_s[0], serial_clock_pin};
        st_nxt.sdi_s  = {st_r.sdi_s[0], alt_serial_in_pin};               // [R03]
        st_nxt.rstp_s = {st_r.rstp_s[0], dev_reset_pin_n};
        st_nxt.pen_s  = {st_r.pen_s[0], serial_program_select_pin_n};
        st_nxt.sck_d  = st_r.sck_s[1];
        // edges found by sampling: needs phases longer than 3 core clocks
        sck_rise = st_r.sck_s[1] && !st_r.sck_d;                           // [R06]
        sck_fall = !st_r.sck_s[1] && st_r.sck_d;

        // strap caught once, held until power down
        if (st_r.strap_cnt != `SMP_STRAP_DONE)
        begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            if (st_nxt.strap_cnt == `SMP_STRAP_DONE)
            begin
                st_nxt.pen_mode = !st_r.pen_s[1];                          // [R10]
            end
        end
        in_mode = st_r.pen_mode || !st_r.rstp_s[1];                        // [R01] [R20]
        st_nxt.in_mode = in_mode;

        // self-timed write countdown
        if (st_r.busy)
        begin
            st_nxt.busy_cnt = st_r.busy_cnt - 1'b1;
            if (st_r.busy_cnt == CNT_W'(1))
            begin
                st_nxt.busy = 1'b0;
            end
        end

        // eeprom erase then write
        if (st_r.q_valid && q_ready)
        begin
            if (st_r.q_op == SMP_OP_EE_ERASE)
            begin
                st_nxt.q_op = SMP_OP_EE_WRITE;                             // [R04]
            end
            else
            begin
                st_nxt.q_valid = 1'b0;
            end
        end

        // read answer lands before the next fall
        if (st_r.rd_wait == `SMP_RD_CAPTURE)
        begin
            st_nxt.out_sr = st_r.rd_ff ? `SMP_ALL_ONES : rd_data;          // [R19] [R21]
        end
        if (st_r.rd_wait != 2'h0)
        begin
            st_nxt.rd_wait = st_r.rd_wait - 2'h1;
        end

        if (!in_mode)
        begin
            // reset pulse resynchronises and drops the enable
            st_nxt.mode     = SMP_MODE_OFF;                                // [R20]
            st_nxt.bit_cnt  = '0;
            st_nxt.byte_cnt = '0;
            st_nxt.out_oe   = 1'b0;
            st_nxt.out_bit  = 1'b0;
            st_nxt.out_sr   = '0;
        end
        else
        begin
            if (st_r.mode == SMP_MODE_OFF)
            begin
                st_nxt.mode = SMP_MODE_WAIT_EN;
            end
            st_nxt.out_oe = 1'b1;                                          // [R03]
            if (sck_fall)
            begin
                st_nxt.out_bit = st_r.out_sr[7];                           // [R08] [R25]
                st_nxt.out_sr  = {st_r.out_sr[6:0], 1'b0};
            end
            if (sck_rise)
            begin
                byte_in = {st_r.in_sr[6:0], st_r.sdi_s[1]};                // [R07] [R25]
                st_nxt.in_sr = byte_in;
                st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
                if (st_r.bit_cnt == `SMP_BIT_LAST)
                begin
                    st_nxt.byte_cnt = st_r.byte_cnt + 2'h1;
                    // each finished byte is echoed during the next one, except the third byte of a read
                    st_nxt.out_sr = byte_in;                               // [R12]
                    b1 = st_r.b1;
                    case (st_r.byte_cnt)
                        2'h0:
                        begin
                            st_nxt.b1 = byte_in;
                        end
                        2'h1:
                        begin
                            st_nxt.b2 = byte_in;
                        end
                        `SMP_BYTE_THIRD:
                        begin
                            st_nxt.b3 = byte_in;
                            // reads resolve now so byte four can carry data
                            if (st_r.mode == SMP_MODE_ENABLED)
                            begin
                                if (b1[7:4] == `SMP_RD_FLASH_HI && b1[2:0] == `SMP_B1_LOW_ZERO)
                                begin
                                    addr = {st_r.b2, byte_in};
                                    st_nxt.rd_req   = 1'b1;                // [R19]
                                    st_nxt.rd_flash = 1'b1;
                                    st_nxt.rd_hi    = b1[`SMP_B1_HBIT];
                                    st_nxt.rd_addr  = addr;
                                    st_nxt.rd_wait  = `SMP_RD_START;
                                    st_nxt.rd_ff    = st_r.busy && (st_r.busy_kind == SMP_BUSY_ERASE
                                        || (st_r.busy_kind == SMP_BUSY_FLASH
                                        && addr[`SMP_ADDR_W-1:`SMP_PAGE_LSB]
                                        == st_r.busy_addr[`SMP_ADDR_W-1:`SMP_PAGE_LSB])); // [R21]
                                end
                                else if (b1 == `SMP_RD_EE_B1)
                                begin
                                    addr = {{`SMP_EE_HI_BITS{1'b0}}, st_r.b2[3:0], byte_in};
                                    st_nxt.rd_req   = 1'b1;                // [R19]
                                    st_nxt.rd_flash = 1'b0;
                                    st_nxt.rd_hi    = 1'b0;
                                    st_nxt.rd_addr  = addr;
                                    st_nxt.rd_wait  = `SMP_RD_START;
                                    // eeprom polls like flash, but matches the whole byte address instead of the page
                                    st_nxt.rd_ff    = st_r.busy && (st_r.busy_kind == SMP_BUSY_ERASE
                                        || (st_r.busy_kind == SMP_BUSY_EE && addr == st_r.busy_addr));
                                end
                            end
                        end
                        default:
                        begin
                            if (b1 == `SMP_ENABLE_B1 && st_r.b2 == `SMP_ENABLE_B2)
                            begin
                                st_nxt.mode = SMP_MODE_ENABLED;            // [R24] [R02] [R13]
                            end
                            // writes dropped while busy or queued
                            else if (st_r.mode == SMP_MODE_ENABLED && !st_r.busy && !st_r.q_valid) // [R17]
                            begin
                                if (b1[7:4] == `SMP_LD_PAGE_HI && b1[2:0] == `SMP_B1_LOW_ZERO)
                                begin
                                    st_nxt.q_valid = 1'b1;                 // [R14]
                                    st_nxt.q_op    = b1[`SMP_B1_HBIT] ? SMP_OP_LOAD_HI : SMP_OP_LOAD_LO;
                                    st_nxt.q_addr  = {{(`SMP_ADDR_W-`SMP_PAGE_LSB){1'b0}},
                                                      st_r.b3[`SMP_PAGE_LSB-1:0]};
                                    st_nxt.q_data  = byte_in;
                                end
                                else if (b1 == `SMP_WR_PAGE_B1)
                                begin
                                    addr = {st_r.b2, st_r.b3[7], {`SMP_PAGE_LSB{1'b0}}};
                                    st_nxt.q_valid   = 1'b1;               // [R15]
                                    st_nxt.q_op      = SMP_OP_WR_PAGE;
                                    st_nxt.q_addr    = addr;
                                    st_nxt.q_data    = '0;
                                    st_nxt.busy      = 1'b1;               // [R21]
                                    st_nxt.busy_kind = SMP_BUSY_FLASH;
                                    st_nxt.busy_cnt  = CNT_W'(FLASH_WAIT_CYC);
                                    st_nxt.busy_addr = addr;
                                end
                                else if (b1 == `SMP_WR_EE_B1)
                                begin
                                    addr = {{`SMP_EE_HI_BITS{1'b0}}, st_r.b2[3:0], st_r.b3};
                                    st_nxt.q_valid   = 1'b1;               // [R18] [R04]
                                    st_nxt.q_op      = SMP_OP_EE_ERASE;
                                    st_nxt.q_addr    = addr;
                                    st_nxt.q_data    = byte_in;
                                    st_nxt.busy      = 1'b1;
                                    st_nxt.busy_kind = SMP_BUSY_EE;
                                    st_nxt.busy_cnt  = CNT_W'(EE_WAIT_CYC);
                                    st_nxt.busy_addr = addr;
                                end
                                else if (b1 == `SMP_ENABLE_B1 && st_r.b2[7:5] == `SMP_ERASE_B2_TOP)
                                begin
                                    st_nxt.q_valid   = 1'b1;               // [R05]
                                    st_nxt.q_op      = SMP_OP_CHIP_ERASE;
                                    st_nxt.q_addr    = '0;
                                    st_nxt.q_data    = `SMP_ALL_ONES;
                                    st_nxt.busy      = 1'b1;
                                    st_nxt.busy_kind = SMP_BUSY_ERASE;
                                    st_nxt.busy_cnt  = CNT_W'(ERASE_WAIT_CYC);
                                    st_nxt.busy_addr = '0;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r           <= '0;
            st_r.mode      <= SMP_MODE_OFF;
            st_r.sck_s     <= '0;
            st_r.rstp_s    <= 2'h3;
            st_r.pen_s     <= 2'h3;
            st_r.q_op      <= SMP_OP_LOAD_LO;
            st_r.busy_kind <= SMP_BUSY_FLASH;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // command buffer toward the array controller
    smp_fifo #(
        .WIDTH (SMP_CMD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (st_r.q_valid),
        .in_ready  (q_ready),
        .in_data   ({st_r.q_op, st_r.q_addr, st_r.q_data}),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  ({cmd_op, cmd_addr, cmd_data})
    );

    assign alt_serial_out_pin = st_r.out_bit;
    assign alt_serial_out_oe  = st_r.out_oe;
    assign prog_mode          = st_r.in_mode;
    assign prog_enabled       = (st_r.mode == SMP_MODE_ENABLED);
    assign nvm_busy           = st_r.busy;
    assign rd_req             = st_r.rd_req;
    assign rd_flash           = st_r.rd_flash;
    assign rd_hi              = st_r.rd_hi;
    assign rd_addr            = st_r.rd_addr;

endmodule

// file: verification/smp_prog_port_assertions.sv
/* smp_chk: pin timing checks.
   assumes all three write wait parameters share the value W. */
`timescale 1ns/10ps
module smp_chk import smp_pkg::*; #(parameter int W = 800) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // pins and status
    input wire logic        dev_reset_pin_n,
    input wire logic        alt_serial_out_oe,
    input wire logic        prog_mode,
    input wire logic        prog_enabled,
    input wire logic        nvm_busy,
    input wire logic        rd_req,
    // command stream
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input smp_pkg::smp_op_t cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0]  cmd_data
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // busy too long for a delay, so counted
    logic [15:0] busy_cnt_r;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n) busy_cnt_r <= 16'h0;
        else busy_cnt_r <= nvm_busy ? busy_cnt_r + 16'h1 : 16'h0;
    AST_BUSY_LEN: assert property ($fell(nvm_busy) |-> busy_cnt_r == 16'(W))
        else $error("busy length wrong");
    AST_RD_PULSE: assert property (rd_req |=> !rd_req) else $error("read pulse long");
    AST_RD_EN: assert property (rd_req |-> prog_enabled) else $error("read not enabled");
    AST_CMD_EN: assert property ($rose(cmd_valid) |-> prog_enabled) else $error("cmd not enabled");
    AST_BUSY_EN: assert property ($rose(nvm_busy) |-> prog_enabled) else $error("busy not enabled");
    AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_op, cmd_addr, cmd_data}))
        else $error("cmd dropped");
    AST_EE_PAIR: assert property (cmd_valid && cmd_ready && cmd_op == SMP_OP_EE_ERASE
        |=> ##[0:2] cmd_valid && cmd_op == SMP_OP_EE_WRITE) else $error("ee pair");
    AST_ENTER: assert property ($fell(dev_reset_pin_n) |-> ##[1:6] prog_mode) else $error("no entry");
    AST_LEAVE: assert property ($rose(dev_reset_pin_n) |-> ##[1:6] !prog_mode && !prog_enabled)
        else $error("no leave");
    AST_OE: assert property ($rose(prog_enabled) |-> alt_serial_out_oe) else $error("oe low");
endmodule
bind smp_prog_port smp_chk #(.W(FLASH_WAIT_CYC)) smp_chk_i (.core_clk, .arst_n, .dev_reset_pin_n,
    .alt_serial_out_oe, .prog_mode, .prog_enabled, .nvm_busy, .rd_req, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_data);

// file: verification/smp_pgm.sv
/* smp_pgm: programmer model on the serial link.
   assumes clk is the device core clock; pins move on its falling edge. */
`timescale 1ns/10ps
module smp_pgm #(parameter int HALF = 4) (
    // pacing
    input wire logic clk,
    // serial link
    input wire logic alt_serial_out_pin,
    output logic     serial_clock_pin,
    output logic     alt_serial_in_pin,
    output logic     dev_reset_pin_n
);
    initial
    begin
        serial_clock_pin = 1'h0;
        alt_serial_in_pin = 1'h0;
        dev_reset_pin_n = 1'h0;
    end
    // 4-cycle phases
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--)
        begin
            alt_serial_in_pin = tx[i];
            repeat (HALF) @(negedge clk);
            serial_clock_pin = 1'h1;
            repeat (HALF) @(negedge clk);
            rx[i] = alt_serial_out_pin; // late capture covers sync delay
            serial_clock_pin = 1'h0;
        end
        repeat (HALF) @(negedge clk);
        alt_serial_in_pin = ~tx[0];
        @(negedge clk);
    endtask
    task automatic pulse(input int n);
        dev_reset_pin_n = 1'h1;
        repeat (n) @(negedge clk);
        dev_reset_pin_n = 1'h0;
    endtask
endmodule

// file: verification/tb_smp_prog_port.sv
/* tb_smp_prog_port: self-checking bench.
   assumes defines, package and design are compiled first. */
`timescale 1ns/10ps
module tb_smp_prog_port;
    import smp_pkg::*;
    localparam int W = 800;
    logic core_clk = 1'h0, arst_n = 1'h0, cmd_ready = 1'h0;
    logic dev_reset_pin_n, serial_clock_pin, alt_serial_in_pin, alt_serial_out_pin, alt_serial_out_oe;
    logic prog_mode, prog_enabled, nvm_busy, rd_req, rd_flash, rd_hi, cmd_valid;
    logic [15:0] rd_addr, cmd_addr;
    logic [7:0] rd_data = 8'h0, cmd_data, a, b, d;
    logic [31:0] rx;
    logic [26:0] exp_q[$];
    smp_op_t cmd_op;
    int num_errors = 0, total_checks = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    smp_prog_port #(.FLASH_WAIT_CYC(W), .EE_WAIT_CYC(W), .ERASE_WAIT_CYC(W)) smp_prog_port_i (.core_clk,
        .arst_n, .dev_reset_pin_n, .serial_program_select_pin_n(1'h1), .serial_clock_pin, .alt_serial_in_pin,
        .alt_serial_out_pin, .alt_serial_out_oe, .prog_mode, .prog_enabled, .nvm_busy, .rd_req, .rd_flash,
        .rd_hi, .rd_addr, .rd_data, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data);
    smp_pgm smp_pgm_i (.clk(core_clk), .alt_serial_out_pin, .serial_clock_pin, .alt_serial_in_pin,
        .dev_reset_pin_n);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [31:0] ins);
        smp_pgm_i.xfer(ins, rx);
    endtask
    // array stub; ready stalls at random
    always @(negedge core_clk)
    begin
        rd_data <= rd_addr[7:0] ^ rd_addr[15:8] ^ {rd_flash, rd_hi, 6'h0};
        cmd_ready <= 1'($urandom);
    end
    // empty queue gives x
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            num_errors++;
            end_of_test();
        end
        if (cmd_valid === 1'h1 && cmd_ready === 1'h1)
            chk({cmd_op, cmd_addr, cmd_op == SMP_OP_WR_PAGE ? 8'h0 : cmd_data}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
    initial
    begin
        void'($urandom(52187));
        repeat (2) @(negedge core_clk);
        arst_n = 1'h1;
        repeat (20) @(negedge core_clk); // shortened settle time
        cmd(32'hc0012345);
        cmd(32'hac530000);
        chk(rx[23:8], 16'hac53);
        chk(prog_enabled, 1'h1);
        exp_q.push_back({SMP_OP_CHIP_ERASE, 16'h0, 8'hff});
        cmd(32'hac800000);
        repeat (W + 50) @(negedge core_clk);
        for (int k = 0; k < 4; k++)
        begin
            if (!k[0]) b = 8'($urandom);
            d = 8'($urandom);
            exp_q.push_back({k[0] ? SMP_OP_LOAD_HI : SMP_OP_LOAD_LO, 9'h0, b[6:0], d});
            cmd({k[0] ? 8'h48 : 8'h40, 8'hff, b, d});
        end
        a = 8'($urandom);
        b = 8'($urandom);
        exp_q.push_back({SMP_OP_WR_PAGE, a, b[7], 7'h0, 8'h0});
        cmd({8'h4c, a, b, 8'h00});
        cmd({8'h28, a, b ^ 8'h15, 8'h00});
        chk(rx[7:0], 8'hff);
        cmd(32'h4000015a);
        repeat (W) @(negedge core_clk);
        cmd({8'h28, a, b, 8'h00});
        chk(rx[7:0], a ^ b ^ 8'hc0);
        d = 8'($urandom);
        exp_q.push_back({SMP_OP_EE_ERASE, 4'h0, a[3:0], b, d});
        exp_q.push_back({SMP_OP_EE_WRITE, 4'h0, a[3:0], b, d});
        cmd({8'hc0, a, b, d});
        repeat (W + 50) @(negedge core_clk);
        cmd({8'ha0, a, b, 8'h00});
        chk(rx[7:0], {4'h0, a[3:0]} ^ b);
        smp_pgm_i.pulse(8);
        chk(prog_enabled, 1'h0);
        cmd(32'hc0012345);
        repeat (50) @(negedge core_clk);
        chk(exp_q.size(), 32'h0);
        end_of_test();
    end
endmodule
